// ==== mmt_pkg.sv ====
// Package of constants and carrier types for the multi-mode timer counter
package mmt_pkg;

  // ---------------------------------------------------------------
  // Widths and values after reset
  // ---------------------------------------------------------------
  localparam int MMT_CNT_W = 16;
  localparam int MMT_DIV_W = 3;
  localparam logic [15:0] MMT_CNT_RST = 16'h0000;
  localparam logic [15:0] MMT_CNT_MAX = 16'hffff;
  localparam logic [15:0] MMT_PERIOD_RST = 16'h0000;
  localparam logic [2:0] MMT_DIV_RST = 3'h0;

  // ---------------------------------------------------------------
  // Counting modes, selected by count_mode_bits
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MMT_MODE_STOP = 2'h0,
    MMT_MODE_UP = 2'h1,
    MMT_MODE_CONT = 2'h2,
    MMT_MODE_UPDN = 2'h3
  } mmt_mode_t;

  // Count direction memory
  typedef enum logic {
    MMT_DIR_UP = 1'b0,
    MMT_DIR_DOWN = 1'b1
  } mmt_dir_t;

  // ---------------------------------------------------------------
  // Carrier structs
  // ---------------------------------------------------------------
  typedef struct packed {
    mmt_mode_t count_mode_bits;
    logic [1:0] div_sel;
    logic counter_clear_bit;
  } mmt_ctrl_t;

  typedef struct packed {
    logic period_match_ie;
    logic timer_wrap_ie;
    logic global_irq_enable;
  } mmt_irq_en_t;

  typedef struct packed {
    logic period_match_flag;
    logic timer_wrap_flag;
  } mmt_flags_t;

endpackage : mmt_pkg

// ==== mmt_clk_div.sv ====
// Timer clock synchroniser and input divider for the timer counter
`timescale 1ns/10ps
`default_nettype none
module mmt_clk_div
  import mmt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tclk_i,
  input wire logic [1:0] div_sel_i,
  input wire logic clear_i,
  output logic tick_o,
  output logic phase_high_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [MMT_DIV_W-1:0] div;
  } mmt_div_state_t;

  mmt_div_state_t st;
  mmt_div_state_t next_st;
  logic [MMT_DIV_W-1:0] mask;
  logic src_rise;

  // Mask of divider bits that must be all ones before a divided edge
  always_comb
  begin
    mask = MMT_DIV_W'((1 << div_sel_i) - 1);
    src_rise = st.sync2 & ~st.prev;
    tick_o = src_rise & ((st.div & mask) == mask);
    // High phase is the first half of a divided period
    if (div_sel_i == 2'h0)
    begin
      phase_high_o = st.sync2;
    end
    else
    begin
      phase_high_o = ~st.div[div_sel_i - 2'h1];
    end
  end

  // Next state; sync1 feeds sync2 only
  always_comb
  begin
    next_st = st;
    next_st.sync1 = tclk_i;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    if (clear_i)
    begin
      next_st.div = MMT_DIV_RST;
    end
    else if (src_rise)
    begin
      next_st.div = st.div + MMT_DIV_W'(1);
    end
  end

  // Register the state
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : mmt_clk_div
`default_nettype wire

// ==== mmt_timer.sv ====
// Multi-mode 16-bit timer counter with period compare and event flags
// Operation
// [RULE1] Changing mode bits only stops or starts; the count value is kept.
// [RULE2] Direction lives in a flip-flop, kept across stops, reset by clear.
// [RULE3] Up mode counts until count reaches or passes period, then zero.
// [RULE4] Up mode sets period match when count reaches the period value.
// [RULE5] Up mode sets wrap on period-to-zero; flags ignore enables.
// [RULE6] Interrupt only when flag, its enable and global enable all set.
// [RULE7] Larger or equal period while running: simply count to it.
// [RULE8] Smaller period in high clock phase: roll or reverse next edge.
// [RULE9] Smaller period in low phase: one more count under old period.
// [RULE10] Continuous mode counts from present value to ffff then zero.
// [RULE11] Continuous mode sets wrap on ffff to zero.
// [RULE12] Continuous mode: period register is a plain compare register.
// [RULE13] Up/down mode counts up to period, then back down to zero.
// [RULE14] Up/down: match on period-1 to period, wrap on one to zero.
// [RULE15] Up/down: each flag once per period, half a period apart.
// [RULE16] Up/down counting up: period update handled as in up mode.
// [RULE17] Up/down counting down: new period waits until count hits zero.
// [RULE18] Clear resets count, divider and direction; then counts up.
// [RULE19] Mode bits pick stop, up, continuous, up/down; timer edge counts.
// [RULE20] Flags set only by counting, never by a software count write.
// [RULE21] Period zero halts up modes; nonzero write restarts from zero.
// [RULE22] Flags stay set until software clears them.
`timescale 1ns/10ps
`default_nettype none
module mmt_timer
  import mmt_pkg::*;
#(
  parameter int CNT_W = MMT_CNT_W
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tclk_i,
  input wire mmt_ctrl_t ctrl_i,
  input wire mmt_irq_en_t irq_en_i,
  input wire logic period_wr_i,
  input wire logic [CNT_W-1:0] period_data_i,
  input wire logic counter_wr_i,
  input wire logic [CNT_W-1:0] counter_data_i,
  input wire mmt_flags_t flag_clr_i,
  output logic [CNT_W-1:0] counter_value_o,
  output logic [CNT_W-1:0] period_compare_register_o,
  output logic count_down_o,
  output mmt_flags_t flags_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // State of the counter
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    mmt_dir_t dir;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] eff;
    logic pend;
    logic pend_at_zero;
    logic [CNT_W-1:0] pend_val;
    mmt_flags_t flags;
  } mmt_state_t;

  localparam logic [CNT_W-1:0] ZERO = CNT_W'(MMT_CNT_RST);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] TOP = CNT_W'(MMT_CNT_MAX);

  mmt_state_t st;
  mmt_state_t next_st;
  logic tick;
  logic phase_high;
  logic match_ev;
  logic wrap_ev;
  logic [CNT_W-1:0] lim;
  logic adopt_now;

  // ---------------------------------------------------------------
  // Timer clock: synchronised, divided, reset by the clear bit
  // ---------------------------------------------------------------
  mmt_clk_div u_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tclk_i(tclk_i),
    .div_sel_i(ctrl_i.div_sel),
    .clear_i(ctrl_i.counter_clear_bit), // [RULE18]
    .tick_o(tick),
    .phase_high_o(phase_high)
  );

  // True when the limited modes are selected
  function automatic logic limited_mode(input mmt_mode_t m);
    limited_mode = (m == MMT_MODE_UP) || (m == MMT_MODE_UPDN);
  endfunction : limited_mode

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    match_ev = 1'b0;
    wrap_ev = 1'b0;
    adopt_now = 1'b0;
    lim = st.eff;

    // Counting steps; mode change itself never touches cnt [RULE1]
    if (tick)
    begin
      case (ctrl_i.count_mode_bits) // [RULE19]
        MMT_MODE_UP:
        begin
          if (st.eff != ZERO) // Zero period halts [RULE21]
          begin
            if (st.cnt >= lim) // [RULE3]
            begin
              next_st.cnt = ZERO;
              wrap_ev = 1'b1; // [RULE5]
            end
            else
            begin
              next_st.cnt = st.cnt + ONE;
              match_ev = (st.cnt + ONE) == lim; // [RULE4]
            end
            // Low-phase shrink: old period served one count [RULE9]
            adopt_now = st.pend && !st.pend_at_zero;
          end
        end
        MMT_MODE_CONT:
        begin
          // Period register acts as a plain compare [RULE12]
          next_st.cnt = st.cnt + ONE; // Wraps at top [RULE10]
          wrap_ev = st.cnt == TOP; // [RULE11]
          match_ev = (st.cnt + ONE) == st.period;
        end
        MMT_MODE_UPDN:
        begin
          if (st.eff != ZERO) // [RULE21]
          begin
            if (st.dir == MMT_DIR_UP)
            begin
              if (st.cnt >= lim) // Reverse at the period [RULE13]
              begin
                next_st.dir = MMT_DIR_DOWN; // [RULE2]
                next_st.cnt = st.cnt - ONE;
                wrap_ev = st.cnt == ONE; // Period of one [RULE14]
              end
              else
              begin
                next_st.cnt = st.cnt + ONE;
                match_ev = (st.cnt + ONE) == lim; // [RULE14] [RULE15]
              end
              adopt_now = st.pend && !st.pend_at_zero; // [RULE16]
            end
            else
            begin
              if (st.cnt == ZERO)
              begin
                next_st.dir = MMT_DIR_UP;
                next_st.cnt = ONE;
                match_ev = ONE == lim;
              end
              else
              begin
                next_st.cnt = st.cnt - ONE;
                wrap_ev = st.cnt == ONE; // [RULE14] [RULE15]
              end
              // Down-count update waits for zero [RULE17]
              adopt_now = st.pend && (next_st.cnt == ZERO);
            end
          end
        end
        MMT_MODE_STOP:
        begin
          // Halted; value and direction held [RULE1] [RULE2]
        end
        default:
        begin
          next_st.cnt = st.cnt;
        end
      endcase
    end

    // Deferred period takes over
    if (adopt_now)
    begin
      next_st.eff = st.pend_val;
      next_st.pend = 1'b0;
      next_st.pend_at_zero = 1'b0;
    end

    // Period register write and its timing handling
    if (period_wr_i)
    begin
      next_st.period = period_data_i;
      if (st.eff == ZERO && period_data_i != ZERO
          && limited_mode(ctrl_i.count_mode_bits))
      begin
        // Restart upward from zero after a zero halt [RULE21]
        next_st.cnt = ZERO;
        next_st.dir = MMT_DIR_UP;
        next_st.eff = period_data_i;
        next_st.pend = 1'b0;
      end
      else if (period_data_i >= st.eff || period_data_i == ZERO
               || !limited_mode(ctrl_i.count_mode_bits))
      begin
        next_st.eff = period_data_i; // [RULE7]
        next_st.pend = 1'b0;
      end
      else if (ctrl_i.count_mode_bits == MMT_MODE_UPDN
               && st.dir == MMT_DIR_DOWN)
      begin
        next_st.pend = 1'b1; // [RULE17]
        next_st.pend_at_zero = 1'b1;
        next_st.pend_val = period_data_i;
      end
      else if (phase_high)
      begin
        next_st.eff = period_data_i; // Acts on next edge [RULE8]
        next_st.pend = 1'b0;
      end
      else
      begin
        next_st.pend = 1'b1; // One more old-period count [RULE9]
        next_st.pend_at_zero = 1'b0;
        next_st.pend_val = period_data_i;
      end
    end

    // Software load of the count sets no flag [RULE20]
    if (counter_wr_i)
    begin
      next_st.cnt = counter_data_i;
    end

    // Clear bit resets count and direction memory [RULE18]
    if (ctrl_i.counter_clear_bit)
    begin
      next_st.cnt = ZERO;
      next_st.dir = MMT_DIR_UP;
    end

    // Load and clear override the step, so its events are dropped [RULE20]
    if (counter_wr_i || ctrl_i.counter_clear_bit)
    begin
      match_ev = 1'b0;
      wrap_ev = 1'b0;
    end

    // Flags: set wins over a clear in the same cycle [RULE22]
    next_st.flags.period_match_flag =
      (st.flags.period_match_flag & ~flag_clr_i.period_match_flag)
      | match_ev;
    next_st.flags.timer_wrap_flag =
      (st.flags.timer_wrap_flag & ~flag_clr_i.timer_wrap_flag)
      | wrap_ev;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs; flags are raised regardless of enables
  // ---------------------------------------------------------------
  assign counter_value_o = st.cnt;
  assign period_compare_register_o = st.period;
  assign count_down_o = st.dir == MMT_DIR_DOWN;
  assign flags_o = st.flags;
  // Request needs flag, own enable and global enable [RULE6]
  assign irq_o = irq_en_i.global_irq_enable
    & ((st.flags.period_match_flag & irq_en_i.period_match_ie)
       | (st.flags.timer_wrap_flag & irq_en_i.timer_wrap_ie));

endmodule : mmt_timer
`default_nettype wire

// ==== mmt_timer_props.sv ====
// Concurrent checks on the ports of the multi-mode timer counter
`timescale 1ns/10ps
`default_nettype none
module mmt_timer_props
  import mmt_pkg::*;
#(
  parameter int CNT_W = MMT_CNT_W
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire mmt_ctrl_t ctrl_i,
  input wire mmt_irq_en_t irq_en_i,
  input wire logic period_wr_i,
  input wire logic counter_wr_i,
  input wire logic [CNT_W-1:0] counter_data_i,
  input wire mmt_flags_t flag_clr_i,
  input wire logic [CNT_W-1:0] counter_value_o,
  input wire logic [CNT_W-1:0] period_compare_register_o,
  input wire logic count_down_o,
  input wire mmt_flags_t flags_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  mmt_mode_t md;
  logic quiet;
  logic [CNT_W-1:0] cnt;
  // Quiet means no clear and no software write this cycle
  assign md = ctrl_i.count_mode_bits;
  assign quiet = !ctrl_i.counter_clear_bit && !counter_wr_i && !period_wr_i;
  assign cnt = counter_value_o;

  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  property p_stop_hold;
    md == MMT_MODE_STOP && quiet |=> $stable(cnt) && $stable(count_down_o);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop moved");
  property p_irq;
    irq_o == (irq_en_i.global_irq_enable &&
      ((flags_o.period_match_flag && irq_en_i.period_match_ie) ||
       (flags_o.timer_wrap_flag && irq_en_i.timer_wrap_ie)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_clear;
    ctrl_i.counter_clear_bit |=> cnt == '0 && !count_down_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_cnt_wr;
    counter_wr_i && !ctrl_i.counter_clear_bit |=> cnt == $past(counter_data_i)
      && !$rose(flags_o.period_match_flag) && !$rose(flags_o.timer_wrap_flag);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("write bad");
  property p_wrap_zero;
    $rose(flags_o.timer_wrap_flag) |-> cnt == '0;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("wrap");
  property p_match;
    $rose(flags_o.period_match_flag) && !$past(period_wr_i)
      |-> cnt == period_compare_register_o;
  endproperty
  a_match: assert property (p_match) else $error("match");
  property p_cont_step;
    md == MMT_MODE_CONT && quiet
      |=> cnt == $past(cnt) || cnt == $past(cnt) + 1'b1;
  endproperty
  a_cont_step: assert property (p_cont_step)
    else $error("cont");
  property p_sticky;
    flags_o != 2'h0
      |=> ($past(flags_o) & ~$past(flag_clr_i) & ~flags_o) == 2'h0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  // Main scenarios reached
  c_updn_wrap: cover property (md == MMT_MODE_UPDN
    && $rose(flags_o.timer_wrap_flag));
  c_cont_wrap: cover property (md == MMT_MODE_CONT
    && $rose(flags_o.timer_wrap_flag));
  c_up_match: cover property (md == MMT_MODE_UP
    && $rose(flags_o.period_match_flag));
  c_irq: cover property (irq_o);
endmodule : mmt_timer_props

bind mmt_timer mmt_timer_props #(.CNT_W(CNT_W)) u_props (.clk_i, .rstn_i,
  .ctrl_i, .irq_en_i, .period_wr_i, .counter_wr_i, .counter_data_i,
  .flag_clr_i, .counter_value_o, .period_compare_register_o,
  .count_down_o, .flags_o, .irq_o);
`default_nettype wire

// ==== test_mmt_timer.sv ====
// Self-checking testbench for the multi-mode timer counter
`timescale 1ns/10ps
`default_nettype none
module test_mmt_timer;
  import mmt_pkg::*;
  typedef struct packed {
    mmt_mode_t m;
    logic [3:0] n;
    logic [15:0] c;
    mmt_flags_t f;
  } mmt_row_t;
  logic clk = 0, rstn = 0, tclk = 0, pwr = 0, cwr = 0, dn, irq;
  logic [15:0] pdat = 0, cdat = 0, cnt, per;
  mmt_ctrl_t ctrl = '0;
  mmt_irq_en_t ien = '0;
  mmt_flags_t fclr = '0, fl;
  int fails = 0;
  int compares = 0;
  // Mode, ticks, count and flags after them; flags cleared per row
  mmt_row_t rows [8] = '{'{MMT_MODE_UP, 4'h3, 16'h0003, 2'h2},
    '{MMT_MODE_UP, 4'h1, 16'h0000, 2'h1},
    '{MMT_MODE_STOP, 4'h2, 16'h0000, 2'h0},
    '{MMT_MODE_UPDN, 4'h3, 16'h0003, 2'h2},
    '{MMT_MODE_UPDN, 4'h1, 16'h0002, 2'h0},
    '{MMT_MODE_STOP, 4'h2, 16'h0002, 2'h0},
    '{MMT_MODE_UPDN, 4'h2, 16'h0000, 2'h1},
    '{MMT_MODE_UPDN, 4'h1, 16'h0001, 2'h0}};

  mmt_timer DUT (.clk_i(clk), .rstn_i(rstn), .tclk_i(tclk), .ctrl_i(ctrl),
    .irq_en_i(ien), .period_wr_i(pwr), .period_data_i(pdat),
    .counter_wr_i(cwr), .counter_data_i(cdat), .flag_clr_i(fclr),
    .counter_value_o(cnt), .period_compare_register_o(per),
    .count_down_o(dn), .flags_o(fl), .irq_o(irq));

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk
  // Slow timer clock: 4 cycles high, 4 low, so the tick lands in time
  task automatic tick(input int n);
    repeat (n)
    begin
      tclk = 1;
      repeat (4) @(negedge clk);
      tclk = 0;
      repeat (4) @(negedge clk);
    end
  endtask : tick
  // One timer clock period with a period write in its high phase
  task automatic tick_wr(input logic [15:0] v);
    tclk = 1;
    repeat (4) @(negedge clk);
    pw(v);
    tclk = 0;
    repeat (4) @(negedge clk);
  endtask : tick_wr
  task automatic pw(input logic [15:0] v);
    pwr = 1;
    pdat = v;
    @(negedge clk);
    pwr = 0;
  endtask : pw
  task automatic fc();
    fclr = 2'h3;
    @(negedge clk);
    fclr = 2'h0;
  endtask : fc
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // ------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------
  initial
  begin
    forever #5 clk = ~clk;
  end
  // A hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial
  begin
    repeat (5) @(negedge clk);
    rstn = 1;
    pw(16'h0003);
    foreach (rows[i])
    begin
      ctrl.count_mode_bits = rows[i].m;
      tick(rows[i].n);
      chk(cnt, rows[i].c);
      chk(16'(fl), 16'(rows[i].f));
      fc();
    end
    tick(3);
    chk(16'(dn), 16'h0001);
    chk(16'(fl), 16'h0002);
    ien = 3'h5;
    #1 chk(16'(irq), 16'h0001);
    ien = 3'h4;
    #1 chk(16'(irq), 16'h0000);
    // Clear drops count and direction, then counts up
    ctrl.counter_clear_bit = 1;
    @(negedge clk);
    ctrl.counter_clear_bit = 0;
    chk(cnt, 16'h0000);
    chk(16'(dn), 16'h0000);
    fc();
    tick(1);
    chk(cnt, 16'h0001);
    ctrl.count_mode_bits = MMT_MODE_UP;
    pw(16'h0000);
    tick(2);
    chk(cnt, 16'h0001);
    pw(16'h0005);
    tick(1);
    chk(cnt, 16'h0001);
    ctrl.count_mode_bits = MMT_MODE_STOP;
    fc();
    cwr = 1;
    cdat = 16'hffff;
    @(negedge clk);
    cwr = 0;
    chk(cnt, 16'hffff);
    chk(16'(fl), 16'h0000);
    ctrl.count_mode_bits = MMT_MODE_CONT;
    tick(1);
    chk(16'(fl), 16'h0001);
    fc();
    tick(6);
    chk(cnt, 16'h0006);
    chk(16'(fl), 16'h0002);
    chk(per, 16'h0005);
    // Larger period while running: count straight on to it
    ctrl.count_mode_bits = MMT_MODE_UP;
    pw(16'h0008);
    fc();
    tick(2);
    chk(cnt, 16'h0008);
    chk(16'(fl), 16'h0002);
    // Smaller period in the low phase: one more count first
    tick(3);
    pw(16'h0002);
    tick(1);
    chk(cnt, 16'h0003);
    tick(1);
    chk(cnt, 16'h0000);
    // Smaller period in the high phase: roll on the next edge
    pw(16'h0006);
    tick(3);
    tick_wr(16'h0002);
    chk(cnt, 16'h0004);
    tick(1);
    chk(cnt, 16'h0000);
    // Up/down while counting up behaves as up mode
    ctrl.count_mode_bits = MMT_MODE_UPDN;
    pw(16'h0006);
    tick(2);
    tick_wr(16'h0002);
    tick(1);
    chk(cnt, 16'h0002);
    chk(16'(dn), 16'h0001);
    // Counting down: the smaller period waits for zero
    pw(16'h0001);
    tick(2);
    chk(cnt, 16'h0000);
    fc();
    tick(2);
    chk(cnt, 16'h0000);
    chk(16'(fl), 16'h0003);
    chk(per, 16'h0001);
    // Divide by two, divider restarted by the clear bit
    ctrl.count_mode_bits = MMT_MODE_CONT;
    ctrl.div_sel = 2'h1;
    ctrl.counter_clear_bit = 1;
    @(negedge clk);
    ctrl.counter_clear_bit = 0;
    tick(4);
    chk(cnt, 16'h0002);
    // Reset in mid-run returns every output to zero
    rstn = 0;
    @(negedge clk);
    rstn = 1;
    chk(cnt, 16'h0000);
    chk(per, 16'h0000);
    chk(16'(fl), 16'h0000);
    chk(16'(dn), 16'h0000);
    complete_run();
  end
endmodule : test_mmt_timer
`default_nettype wire
